/* design/lfd_params.svh */
// Constants for the literal and file operation decoder.
`ifndef LFD_PARAMS_SVH
`define LFD_PARAMS_SVH

// ************************************************************
// Data path widths and field positions
// ************************************************************
`define LFD_DATA_W 8
`define LFD_ADDR_W 7
`define LFD_INSTR_W 14
`define LFD_DEST_BIT 7
`define LFD_ADDR_MSB 6
`define LFD_LIT_MSB 7

// ************************************************************
// Opcode fields, matched against the top bits of the word; idle also matches bits 4:0, prescale the whole word
// ************************************************************
// Six-bit opcodes in bits 13:8.
`define LFD_OP6_ADD_REG 6'h07
`define LFD_OP6_AND_REG 6'h05
`define LFD_OP6_INC_SKIP 6'h0f
`define LFD_OP6_OR_REG 6'h04
`define LFD_OP6_COPY_REG 6'h08
`define LFD_OP6_AND_LIT 6'h39
`define LFD_OP6_OR_LIT 6'h38
// Five-bit opcode in bits 13:9, bit 8 ignored.
`define LFD_OP5_ADD_LIT 5'h1f
// Four-bit opcode in bits 13:10, bits 9:8 ignored.
`define LFD_OP4_LOAD_LIT 4'hc
// Seven-bit opcode in bits 13:7 for the store.
`define LFD_OP7_STORE 7'h01
// Idle: bits 13:7 and 4:0 zero, bits 6:5 ignored.
`define LFD_IDLE_HI 7'h00
`define LFD_IDLE_LO 5'h00
// Whole word of the legacy prescale load.
`define LFD_PRESCALE_WORD 14'h0062

// ************************************************************
// Reset values and constants
// ************************************************************
`define LFD_ACC_RST 8'h00
`define LFD_PRESCALE_RST 8'hff
`define LFD_ONE 8'h01
`define LFD_ZERO 8'h00

`endif

/* design/lfd_pkg.sv */
// Types shared by the literal and file operation decoder.
`default_nettype none
`include "lfd_params.svh"

package lfd_pkg;

  // ************************************************************
  // Sequencer states, one-hot
  // ************************************************************
  typedef enum logic [1:0] {
    LFD_ST_EXEC = 2'h1,
    LFD_ST_SKIP = 2'h2
  } lfd_state_e;

  // Operation chosen for the arithmetic unit.
  typedef enum logic [1:0] {
    LFD_ALU_ADD = 2'h0,
    LFD_ALU_AND = 2'h1,
    LFD_ALU_OR = 2'h2,
    LFD_ALU_PASS = 2'h3
  } lfd_alu_e;

  // Status flags kept by the core.
  typedef struct packed {
    logic byteOvf;
    logic nibbleOvf;
    logic resultNull;
  } lfd_flags_s;

  // One write toward the data register file.
  typedef struct packed {
    logic en;
    logic [`LFD_ADDR_W-1:0] addr;
    logic [`LFD_DATA_W-1:0] data;
  } lfd_wr_s;

endpackage

`default_nettype wire

/* design/lfd_alu.sv */
// Combinational arithmetic and logic unit for the decoder.
`default_nettype none
`include "lfd_params.svh"

module lfd_alu #(
  parameter int W = `LFD_DATA_W
) (
  input wire logic [W-1:0] opA,
  input wire logic [W-1:0] opB,
  input wire lfd_pkg::lfd_alu_e aluOp,
  output logic [W-1:0] result,
  output logic carryOut,
  output logic halfCarry
);

  // ************************************************************
  // Adder with both carries
  // ************************************************************
  // The sum is one bit wider so the carry out of the top bit shows.
  logic [W:0] sumFull;
  // Low nibble sum gives the carry out of bit 3.
  logic [4:0] sumLow;

  assign sumFull = {1'b0, opA} + {1'b0, opB};
  assign sumLow = {1'b0, opA[3:0]} + {1'b0, opB[3:0]};

  // ************************************************************
  // Result selection
  // ************************************************************
  // Pass hands the second operand straight through.
  assign result = (aluOp == lfd_pkg::LFD_ALU_ADD) ? sumFull[W-1:0] :
                  (aluOp == lfd_pkg::LFD_ALU_AND) ? (opA & opB) :
                  (aluOp == lfd_pkg::LFD_ALU_OR) ? (opA | opB) : opB;
  // Carries are meaningful only for the add; callers ignore them else.
  assign carryOut = sumFull[W];
  assign halfCarry = sumLow[4];

endmodule

`default_nettype wire

/* design/lfd_decoder.sv */
// Decoder and executor for literal and file register operations.
// How it works
// (RL1) Add literal to accumulator, all three flags.
// (RL2) AND literal into accumulator, null flag only.
// (RL3) Add register to accumulator, all three flags.
// (RL4) Destination bit picks accumulator or register.
// (RL5) AND register with accumulator, null flag only.
// (RL6) Increment register, flags left untouched.
// (RL7) Zero increment result drops next fetched word.
// (RL8) OR register with accumulator, null flag only.
// (RL9) OR literal into accumulator, null flag only.
// (RL10) Load literal, flags untouched, ignored bits free.
// (RL11) Copy register to destination, null flag updated.
// (RL12) Store accumulator into register, flags untouched.
// (RL13) Legacy load copies accumulator into prescale.
// (RL14) Idle word changes nothing in one cycle.
// (RL15) Null, byte and nibble carries follow result.
`default_nettype none
`include "lfd_params.svh"

module lfd_decoder #(
  parameter int DW = `LFD_DATA_W,
  parameter int AW = `LFD_ADDR_W
) (
  input wire logic core_clk,
  input wire logic sys_rst,
  input wire logic instrValid,
  input wire logic [`LFD_INSTR_W-1:0] instrWord,
  input wire logic [DW-1:0] regRdData,
  output logic [AW-1:0] regRdAddr,
  output lfd_pkg::lfd_wr_s regWrQ,
  output logic [DW-1:0] accQ,
  output lfd_pkg::lfd_flags_s flagsQ,
  output logic [DW-1:0] prescaleQ,
  output logic skipActiveQ,
  output logic badOpQ
);

  // ************************************************************
  // Instruction fields
  // ************************************************************
  // Literal operand of the literal forms.
  logic [DW-1:0] litVal;
  // File register address of the register forms.
  logic [AW-1:0] regAddr;
  // Destination select, zero means accumulator.
  logic destToReg;

  assign litVal = instrWord[`LFD_LIT_MSB:0];
  assign regAddr = instrWord[`LFD_ADDR_MSB:0];
  assign destToReg = instrWord[`LFD_DEST_BIT];
  // The read address is registered from the address field of the word, one cycle late.
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      regRdAddr <= '0;
    end else begin
      regRdAddr <= regAddr;
    end
  end

  // ************************************************************
  // Opcode decode
  // ************************************************************
  logic isAddLit, isAndLit, isOrLit, isLoadLit;
  logic isAddReg, isAndReg, isOrReg, isIncSkip, isCopyReg;
  logic isStore, isPrescale, isIdle, isKnown;

  assign isAddLit = instrWord[13:9] == `LFD_OP5_ADD_LIT; // [RL1]
  assign isAndLit = instrWord[13:8] == `LFD_OP6_AND_LIT; // [RL2]
  assign isOrLit = instrWord[13:8] == `LFD_OP6_OR_LIT; // [RL9]
  // Bits 9:8 are left out of the match on purpose.
  assign isLoadLit = instrWord[13:10] == `LFD_OP4_LOAD_LIT; // [RL10]
  assign isAddReg = instrWord[13:8] == `LFD_OP6_ADD_REG; // [RL3]
  assign isAndReg = instrWord[13:8] == `LFD_OP6_AND_REG; // [RL5]
  assign isOrReg = instrWord[13:8] == `LFD_OP6_OR_REG; // [RL8]
  assign isIncSkip = instrWord[13:8] == `LFD_OP6_INC_SKIP; // [RL6]
  assign isCopyReg = instrWord[13:8] == `LFD_OP6_COPY_REG; // [RL11]
  assign isStore = instrWord[13:7] == `LFD_OP7_STORE; // [RL12]
  assign isPrescale = instrWord == `LFD_PRESCALE_WORD; // [RL13]
  // Bits 6:5 of the idle word may hold anything.
  assign isIdle = (instrWord[13:7] == `LFD_IDLE_HI) &&
                  (instrWord[4:0] == `LFD_IDLE_LO); // [RL14]
  assign isKnown = isAddLit | isAndLit | isOrLit | isLoadLit |
                   isAddReg | isAndReg | isOrReg | isIncSkip |
                   isCopyReg | isStore | isPrescale | isIdle;

  // ************************************************************
  // Operand routing
  // ************************************************************
  logic litForm, regForm;
  // Register operand, with the pending write forwarded.
  logic [DW-1:0] regOperand;
  logic [DW-1:0] aluA, aluB, aluRes;
  logic aluCarry, aluHalf;
  lfd_pkg::lfd_alu_e aluOp;

  assign litForm = isAddLit | isAndLit | isOrLit | isLoadLit;
  assign regForm = isAddReg | isAndReg | isOrReg | isIncSkip |
                   isCopyReg;
  // The registered write lands a cycle late, so a back-to-back read of
  // the same address would see stale data without this bypass.
  assign regOperand = (regWrQ.en && regWrQ.addr == regAddr) ?
                      regWrQ.data : regRdData;
  assign aluA = isIncSkip ? regOperand : accQ;
  assign aluB = isIncSkip ? `LFD_ONE :
                litForm ? litVal : regOperand;
  assign aluOp = (isAddLit | isAddReg | isIncSkip) ?
                 lfd_pkg::LFD_ALU_ADD :
                 (isAndLit | isAndReg) ? lfd_pkg::LFD_ALU_AND :
                 (isOrLit | isOrReg) ? lfd_pkg::LFD_ALU_OR :
                 lfd_pkg::LFD_ALU_PASS;

  lfd_alu #(
    .W(DW)
  ) uAlu (
    .opA(aluA),
    .opB(aluB),
    .aluOp(aluOp),
    .result(aluRes),
    .carryOut(aluCarry),
    .halfCarry(aluHalf)
  );

  // ************************************************************
  // Sequencer and execute qualifiers
  // ************************************************************
  lfd_pkg::lfd_state_e stateQ, stateD;
  logic execNow, dropNow, skipNext;

  // Only a word fetched while executing is acted on.
  assign execNow = instrValid && (stateQ == lfd_pkg::LFD_ST_EXEC);
  // The word that follows a zero increment is thrown away.
  assign dropNow = instrValid && (stateQ == lfd_pkg::LFD_ST_SKIP);
  assign skipNext = execNow && isIncSkip &&
                    (aluRes == `LFD_ZERO); // [RL7]

  // Next state: skip lasts exactly one fetched word.
  always_comb begin
    stateD = stateQ;
    case (stateQ)
      lfd_pkg::LFD_ST_EXEC: begin
        if (skipNext) begin
          stateD = lfd_pkg::LFD_ST_SKIP; // [RL7]
        end
      end
      lfd_pkg::LFD_ST_SKIP: begin
        if (dropNow) begin
          stateD = lfd_pkg::LFD_ST_EXEC; // [RL7]
        end
      end
      default: begin
        stateD = lfd_pkg::LFD_ST_EXEC;
      end
    endcase
  end

  // ************************************************************
  // Result steering
  // ************************************************************
  logic accWr, regWr, updNull, updCarry;
  logic [DW-1:0] accD, prescaleD;
  lfd_pkg::lfd_flags_s flagsD;
  lfd_pkg::lfd_wr_s regWrD;

  // Literal forms always land in the accumulator.
  assign accWr = execNow && (litForm ||
                 (regForm && !destToReg)); // [RL4]
  assign regWr = execNow && ((regForm && destToReg) ||
                 isStore); // [RL4] [RL12]
  assign updCarry = execNow && (isAddLit || isAddReg); // [RL1] [RL3]
  assign updNull = updCarry || (execNow && (isAndLit || isAndReg ||
                   isOrLit || isOrReg || isCopyReg)); // [RL11]
  assign accD = accWr ? aluRes : accQ;
  assign regWrD.en = regWr;
  assign regWrD.addr = regAddr;
  assign regWrD.data = isStore ? accQ : aluRes; // [RL12]
  assign prescaleD = (execNow && isPrescale) ? accQ :
                     prescaleQ; // [RL13]
  // Load, store, increment, idle and prescale keep every flag.
  assign flagsD.resultNull = updNull ? (aluRes == `LFD_ZERO) :
                             flagsQ.resultNull; // [RL15]
  assign flagsD.byteOvf = updCarry ? aluCarry :
                          flagsQ.byteOvf; // [RL15]
  assign flagsD.nibbleOvf = updCarry ? aluHalf :
                            flagsQ.nibbleOvf; // [RL15]

  // ************************************************************
  // State registers
  // ************************************************************
  // Core state, all taken from constants under reset.
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      stateQ <= lfd_pkg::LFD_ST_EXEC;
      accQ <= `LFD_ACC_RST;
      flagsQ <= '0;
      prescaleQ <= `LFD_PRESCALE_RST;
    end else begin
      stateQ <= stateD;
      accQ <= accD;
      flagsQ <= flagsD;
      prescaleQ <= prescaleD;
    end
  end

  // Registered outputs toward the file and the fetch side.
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      regWrQ <= '0;
      skipActiveQ <= 1'b0;
      badOpQ <= 1'b0;
    end else begin
      regWrQ <= regWrD;
      skipActiveQ <= (stateD == lfd_pkg::LFD_ST_SKIP);
      // Unknown words execute as idle but are reported.
      badOpQ <= execNow && !isKnown;
    end
  end

  // ************************************************************
  // Checks
  // ************************************************************
  default clocking @(posedge core_clk); endclocking
  default disable iff (sys_rst);

  addLit_result_a: assert property ( // [RL1]
    execNow && isAddLit |=> accQ == DW'($past(accQ) + $past(litVal)))
    else $error("add literal result wrong");

  andLit_flags_a: assert property ( // [RL2]
    execNow && isAndLit |=> accQ == ($past(accQ) & $past(litVal))
      && flagsQ.byteOvf == $past(flagsQ.byteOvf)
      && flagsQ.nibbleOvf == $past(flagsQ.nibbleOvf))
    else $error("and literal changed wrong state");

  addReg_carry_a: assert property ( // [RL3]
    execNow && isAddReg |=> flagsQ.byteOvf ==
      (({1'b0, $past(accQ)} + {1'b0, $past(regOperand)}) > 9'h0ff))
    else $error("add register byte carry wrong");

  dest_select_a: assert property ( // [RL4]
    execNow && regForm |=> regWrQ.en == $past(destToReg)
      && (regWrQ.en || accQ == $past(aluRes)))
    else $error("destination select wrong");

  orReg_result_a: assert property ( // [RL8]
    execNow && isOrReg && !destToReg
      |=> accQ == ($past(accQ) | $past(regOperand)))
    else $error("or register result wrong");

  inc_flags_a: assert property ( // [RL6]
    execNow && isIncSkip |=> $stable(flagsQ) ##1 1'b1)
    else $error("increment touched flags");

  skip_drop_a: assert property ( // [RL7]
    skipNext ##1 instrValid |=> $stable(accQ) && !regWrQ.en
      && stateQ == lfd_pkg::LFD_ST_EXEC)
    else $error("word after zero increment not dropped");

  loadLit_value_a: assert property ( // [RL10]
    execNow && isLoadLit |=> accQ == $past(litVal) && $stable(flagsQ))
    else $error("load literal wrong");

  store_write_a: assert property ( // [RL12]
    execNow && isStore |=> regWrQ.en && regWrQ.data == $past(accQ)
      && regWrQ.addr == $past(regAddr) && $stable(flagsQ))
    else $error("store accumulator wrong");

  prescale_load_a: assert property ( // [RL13]
    execNow && isPrescale |=> prescaleQ == $past(accQ)
      && $stable(flagsQ) && $stable(accQ))
    else $error("prescale load wrong");

  idle_quiet_a: assert property ( // [RL14]
    execNow && isIdle |=> $stable(accQ) && $stable(flagsQ)
      && !regWrQ.en && $stable(prescaleQ))
    else $error("idle changed state");

  null_flag_a: assert property ( // [RL15] [RL11]
    updNull |=> flagsQ.resultNull == ($past(aluRes) == `LFD_ZERO))
    else $error("null flag wrong");

  // A d=1 AND must write the masked value back and leave the byte carry.
  andReg_result_a: assert property ( // [RL5]
    execNow && isAndReg && destToReg
      |=> regWrQ.data == ($past(accQ) & $past(regOperand))
      && $stable(accQ) && flagsQ.byteOvf == $past(flagsQ.byteOvf))
    else $error("and register result wrong");

  orLit_result_a: assert property ( // [RL9]
    execNow && isOrLit |=> accQ == ($past(accQ) | $past(litVal))
      && flagsQ.nibbleOvf == $past(flagsQ.nibbleOvf))
    else $error("or literal result wrong");

  // The copied byte lands in whichever destination the word picks.
  copyReg_value_a: assert property ( // [RL11]
    execNow && isCopyReg
      |=> (regWrQ.en ? regWrQ.data : accQ) == $past(regOperand))
    else $error("copy register value wrong");

  add_nibble_a: assert property ( // [RL15]
    execNow && (isAddLit || isAddReg) |=> flagsQ.nibbleOvf ==
      (({1'b0, $past(accQ[3:0])} + {1'b0, $past(aluB[3:0])}) > 5'h0f))
    else $error("nibble carry wrong");

  skip_flag_a: assert property ( // [RL7]
    execNow && isIncSkip |=> skipActiveQ == ($past(aluRes) == `LFD_ZERO))
    else $error("skip flag wrong");

endmodule

`default_nettype wire

/* testbench/lfd_file_model.sv */
// Behavioural data register file standing beside the decoder.
`default_nettype none
`include "lfd_params.svh"

module lfd_file_model (
  input wire logic core_clk,
  input wire logic fetchValid,
  input wire logic [`LFD_ADDR_W-1:0] rdAddr,
  output logic [`LFD_DATA_W-1:0] rdData,
  input wire lfd_pkg::lfd_wr_s wrReq
);
  timeunit 1ns;
  timeprecision 1ns;

  // ************************************************************
  // Storage
  // ************************************************************
  // Each register starts out holding its own address.
  logic [`LFD_DATA_W-1:0] mem [0:127];

  initial begin
    for (int i = 0; i < 128; i++) begin
      mem[i] = 8'(i);
    end
  end

  // Reads are asynchronous; with no fetch the bus shows inverted junk.
  // That way a design that samples outside a fetch cannot get lucky.
  assign rdData = fetchValid ? mem[rdAddr] : ~mem[rdAddr];

  // A write lands on the edge that sees the enable pulse.
  always @(posedge core_clk) begin
    if (wrReq.en === 1'b1) begin
      mem[wrReq.addr] <= wrReq.data;
    end
  end

endmodule

`default_nettype wire

/* testbench/tb.sv */
// Self-checking bench for the literal and file operation decoder.
`default_nettype none
`include "lfd_params.svh"

module tb;
  timeunit 1ns;
  timeprecision 1ns;

  // ************************************************************
  // Signals and the table of ordinary cases
  // ************************************************************
  // One row: the word, then accumulator, flags and write it leaves.
  typedef struct packed {
    logic [13:0] w;
    logic [7:0] acc;
    logic [2:0] fl;
    lfd_pkg::lfd_wr_s wr;
  } lfd_row_s;

  logic core_clk = 1'b0;
  logic sys_rst = 1'b1;
  logic instrValid = 1'b0;
  logic [13:0] instrWord = 14'h0000;
  logic [7:0] regRdData;
  logic [6:0] regRdAddr;
  lfd_pkg::lfd_wr_s regWrQ;
  logic [7:0] accQ;
  lfd_pkg::lfd_flags_s flagsQ;
  logic [7:0] prescaleQ;
  logic skipActiveQ;
  logic badOpQ;
  int fails = 0;
  int total_checks = 0;

  // Flags are byte carry, nibble carry, null; registers hold their address.
  lfd_row_s rows [22] = '{
    '{14'h339a, 8'h9a, 3'h0, 16'h0000},
    '{14'h3835, 8'hbf, 3'h0, 16'h0000},
    '{14'h3940, 8'h00, 3'h1, 16'h0000},
    '{14'h3e10, 8'h10, 3'h0, 16'h0000},
    '{14'h3ff8, 8'h08, 3'h4, 16'h0000},
    '{14'h3800, 8'h08, 3'h4, 16'h0000},
    '{14'h3f08, 8'h10, 3'h2, 16'h0000},
    '{14'h00a0, 8'h10, 3'h2, 16'ha010},
    '{14'h0720, 8'h20, 3'h0, 16'h0000},
    '{14'h07b0, 8'h20, 3'h0, 16'hb050},
    '{14'h0531, 8'h20, 3'h0, 16'h0000},
    '{14'h058f, 8'h20, 3'h1, 16'h8f00},
    '{14'h0405, 8'h25, 3'h0, 16'h0000},
    '{14'h0486, 8'h25, 3'h0, 16'h8627},
    '{14'h0800, 8'h00, 3'h1, 16'h0000},
    '{14'h0060, 8'h00, 3'h1, 16'h0000},
    '{14'h0000, 8'h00, 3'h1, 16'h0000},
    '{14'h0f07, 8'h08, 3'h1, 16'h0000},
    '{14'h0f88, 8'h08, 3'h1, 16'h8809},
    '{14'h08c1, 8'h08, 3'h0, 16'hc141},
    '{14'h077f, 8'h87, 3'h2, 16'h0000},
    '{14'h3f79, 8'h00, 3'h7, 16'h0000}
  };

  always #25 core_clk = ~core_clk;

  lfd_decoder u_dut (
    .core_clk(core_clk),
    .sys_rst(sys_rst),
    .instrValid(instrValid),
    .instrWord(instrWord),
    .regRdData(regRdData),
    .regRdAddr(regRdAddr),
    .regWrQ(regWrQ),
    .accQ(accQ),
    .flagsQ(flagsQ),
    .prescaleQ(prescaleQ),
    .skipActiveQ(skipActiveQ),
    .badOpQ(badOpQ)
  );

  lfd_file_model u_mem (
    .core_clk(core_clk),
    .fetchValid(instrValid),
    .rdAddr(instrWord[6:0]),
    .rdData(regRdData),
    .wrReq(regWrQ)
  );

  // ************************************************************
  // Compare tasks and stimulus helpers
  // ************************************************************
  // Counts one comparison and reports a failed one at once.
  task automatic note(input bit ok, input string m);
    total_checks++;
    if (!ok) begin
      fails++;
      $display("MISMATCH at %0t: %s", $time, m);
    end
  endtask

  task automatic check_data(input logic [7:0] g, e, input string m);
    note(g === e, $sformatf("%s got %h want %h", m, g, e));
  endtask

  task automatic check_flags(input lfd_pkg::lfd_flags_s g, e);
    note(g === e, $sformatf("flags got %b want %b", g, e));
  endtask

  task automatic check_bit(input logic g, e, input string m);
    note(g === e, $sformatf("%s got %b want %b", m, g, e));
  endtask

  // Address and data only matter while the enable is up.
  task automatic check_write(input lfd_pkg::lfd_wr_s g, e);
    note(g.en === e.en && (!e.en || g === e),
      $sformatf("write got %h want %h", g, e));
  endtask

  // Accumulator, flags and file write after the last word.
  task automatic expect_state(input logic [7:0] a, input logic [2:0] f,
                              input logic [15:0] w);
    check_data(accQ, a, "acc");
    check_flags(flagsQ, f);
    check_write(regWrQ, w);
  endtask

  // Presents one word at the falling edge, returns one cycle later.
  task automatic step(input logic v, input logic [13:0] w);
    instrValid = v;
    instrWord = w;
    @(negedge core_clk);
  endtask

  task automatic give_verdict();
    $display("Checks %0d, mismatches %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  // A hung run is cut short and counted as a failure.
  initial begin
    repeat (500) @(posedge core_clk);
    fails++;
    $display("MISMATCH at %0t: run did not finish", $time);
    give_verdict();
  end

  // ************************************************************
  // Main sequence
  // ************************************************************
  initial begin
    repeat (5) @(negedge core_clk);
    expect_state(8'h00, 3'h0, 16'h0000);
    check_data(prescaleQ, 8'hff, "reset prescale");
    check_bit(skipActiveQ, 1'b0, "reset skip");
    check_data({1'b0, regRdAddr}, 8'h00, "reset rd addr");
    sys_rst = 1'b0;
    // Back-to-back words, one row per cycle.
    foreach (rows[i]) begin
      step(1'b1, rows[i].w);
      expect_state(rows[i].acc, rows[i].fl, rows[i].wr);
      check_bit(badOpQ, 1'b0, "bad op");
      check_bit(skipActiveQ, 1'b0, "no skip");
      // The read address register follows the word's address field.
      check_data({1'b0, regRdAddr}, 8'(rows[i].w[6:0]), "rd addr");
    end
    $display("table test done");
    // An unknown word must behave as idle.
    step(1'b1, 14'h3a00);
    expect_state(8'h00, 3'h7, 16'h0000);
    check_bit(badOpQ, 1'b1, "bad op pulse");
    step(1'b1, 14'h3077);
    step(1'b1, 14'h0062);
    check_data(prescaleQ, 8'h77, "prescale");
    expect_state(8'h77, 3'h7, 16'h0000);
    $display("legacy and unknown test done");
    // Zero increment, the very next word is dropped.
    step(1'b1, 14'h30ff);
    step(1'b1, 14'h00d0);
    check_write(regWrQ, 16'hd0ff);
    step(1'b1, 14'h00d1);
    step(1'b1, 14'h0fd0);
    expect_state(8'hff, 3'h7, 16'hd000);
    check_bit(skipActiveQ, 1'b1, "skip set");
    step(1'b1, 14'h3011);
    expect_state(8'hff, 3'h7, 16'h0000);
    check_bit(skipActiveQ, 1'b0, "skip clear");
    // Cycles with no fetch in between do not use up the skip.
    step(1'b1, 14'h0f51);
    expect_state(8'h00, 3'h7, 16'h0000);
    step(1'b0, 14'h3033);
    step(1'b0, 14'h3033);
    check_bit(skipActiveQ, 1'b1, "skip held");
    step(1'b1, 14'h3011);
    check_data(accQ, 8'h00, "dropped word");
    step(1'b1, 14'h3022);
    check_data(accQ, 8'h22, "after skip");
    $display("skip test done");
    // Reset in mid-run clears a pending skip and a pending write.
    step(1'b1, 14'h0fd1);
    check_write(regWrQ, 16'hd100);
    check_bit(skipActiveQ, 1'b1, "skip before reset");
    instrValid = 1'b0;
    sys_rst = 1'b1;
    @(negedge core_clk);
    expect_state(8'h00, 3'h0, 16'h0000);
    check_bit(skipActiveQ, 1'b0, "skip after reset");
    check_data(prescaleQ, 8'hff, "prescale after reset");
    check_data({1'b0, regRdAddr}, 8'h00, "rd addr after reset");
    sys_rst = 1'b0;
    step(1'b1, 14'h3011);
    check_data(accQ, 8'h11, "first word after reset");
    // A register add that carries out of both bit 3 and bit 7.
    step(1'b1, 14'h30ff);
    step(1'b1, 14'h0702);
    expect_state(8'h01, 3'h6, 16'h0000);
    instrValid = 1'b0;
    $display("reset test done");
    give_verdict();
  end

endmodule

`default_nettype wire
